// ==== rtl/lier_consts.svh ====
// Function
// R01 - Event bit sets on source rising edge or software write of 1 at set address.
// R02 - Event bit clears only by software writing 1 at the clear address.
// R03 - Event register reads return latched events ANDed with the interrupt mask.
// R04 - Bit 31 is reserved and always reads 0.
// R05 - Software must never write bit 30; it is a reserved settable position.
// R06 - Bit 29 is a software interrupt, set and cleared only by software.
// R07 - Bit 28 is reserved and always reads 0.
// R08 - Bit 27 sets only while late-ack enable is 1 and a late condition arises. The code also sets it on a set write, whatever the enable.
// R09 - Bit 26 sets when a PHY register byte arrives; byte readable at bits 23..16.
// R10 - With root enable set, bit 25 sets when cycle exceeds 125 us to gap end.
// R11 - Raising the cycle overrun event clears the timing root enable.
// R12 - Bit 24 sets whenever an error halts any subunit or context. The code has no subunit input and watches only the NCTX context halt inputs.
// R13 - While bit 24 is 1, normal events of faulting contexts are blocked.
// R14 - Bit 23 sets when received cycle start seconds or count differ from timer.
// R15 - Interrupt request is high whenever the masked event value is nonzero.
`ifndef LIER_CONSTS_SVH
`define LIER_CONSTS_SVH

`define LIER_OFF_EV_SET 8'h80
`define LIER_OFF_EV_CLR 8'h84
`define LIER_OFF_MASK 8'h88
`define LIER_OFF_CTRL 8'h8c
`define LIER_OFF_PHY 8'h90

`define LIER_BIT_RSVD31 31
`define LIER_BIT_VENDOR 30
`define LIER_BIT_SOFT 29
`define LIER_BIT_RSVD28 28
`define LIER_BIT_LATE 27
`define LIER_BIT_PHY 26
`define LIER_BIT_OVERRUN 25
`define LIER_BIT_FATAL 24
`define LIER_BIT_MISMATCH 23

`define LIER_CTRL_LATE_EN 29
`define LIER_CTRL_ROOT_EN 21
`define LIER_PHY_LSB 16

`define LIER_EV_IMPL 32'h6f800000
`define LIER_EV_RESET 32'h00000000
`define LIER_MASK_RESET 32'h00000000
`define LIER_CTRL_RESET 32'h00000000

`define LIER_CYCLE_TIME_NS 125000
`define LIER_CLK_PERIOD_NS 20
`define LIER_OVERRUN_CYC (`LIER_CYCLE_TIME_NS / `LIER_CLK_PERIOD_NS)

`endif

// ==== rtl/lier_pkg.sv ====
package lier_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lier_bus_t;

  typedef struct packed {
    logic rx_fifo_pending;
    logic phys_resp_busy;
    logic ack_tardy_sent;
    logic phy_byte_valid;
    logic [7:0] phy_byte;
    logic cyc_start_tx;
    logic subaction_gap_end;
  } lier_src_t;

  typedef struct packed {
    logic valid;
    logic [6:0] timer_seconds_field;
    logic [12:0] timer_tick_field;
  } lier_cyc_t;

  typedef enum logic [1:0] {
    LIER_IDLE = 2'b00,
    LIER_TIMING = 2'b01,
    LIER_OVER = 2'b11
  } lier_state_t;

endpackage : lier_pkg

// ==== rtl/lier_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lier_consts.svh"

module lier_top #(
  parameter int NCTX = 4,
  parameter int OVERRUN_CYCLES = `LIER_OVERRUN_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire lier_pkg::lier_bus_t bus_i,
  output logic [31:0] rdata_o,
  input wire lier_pkg::lier_src_t src_i,
  input wire lier_pkg::lier_cyc_t rx_cyc_i,
  input wire lier_pkg::lier_cyc_t timer_i,
  input wire logic [NCTX-1:0] ctx_halted_i,
  output logic [NCTX-1:0] ctx_block_o,
  output logic isoch_timing_root_enable_o,
  output logic irq_o
);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  function automatic logic hit(input lier_pkg::lier_bus_t b, input logic [7:0] off);
    hit = (b.addr == off);
  endfunction : hit

  logic [31:0] ev_ff, nxt_ev;
  logic [31:0] mask_ff, nxt_mask;
  logic late_en_ff, nxt_late_en;
  logic root_en_ff, nxt_root_en;
  logic [7:0] phy_byte_ff, nxt_phy_byte;
  logic [31:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic [NCTX-1:0] block_ff, nxt_block;
  logic [NCTX-1:0] halted_prev_ff;
  logic late_prev_ff, phy_prev_ff, cyc_prev_ff;
  lier_pkg::lier_state_t state_ff, nxt_state;
  logic [12:0] cnt_ff, nxt_cnt;

  wire wr_set = bus_i.wr & hit(bus_i, `LIER_OFF_EV_SET);
  wire wr_clr = bus_i.wr & hit(bus_i, `LIER_OFF_EV_CLR);
  wire wr_mask = bus_i.wr & hit(bus_i, `LIER_OFF_MASK);
  wire wr_ctrl = bus_i.wr & hit(bus_i, `LIER_OFF_CTRL);
  wire [31:0] ev_impl = `LIER_EV_IMPL;

  // Software may touch only implemented positions; 31 and 28 never store
  wire [31:0] sw_set = wr_set ? (bus_i.wdata & ev_impl) : 32'h00000000; // R01 R06
  wire [31:0] sw_clr = wr_clr ? (bus_i.wdata & ev_impl) : 32'h00000000; // R02 R06

  // Late-ack condition is gated by the enable before edge detection
  wire late_lvl = late_en_ff &
    (src_i.rx_fifo_pending | src_i.phys_resp_busy | src_i.ack_tardy_sent); // R08
  wire late_hit = rise(late_lvl, late_prev_ff); // R08
  wire phy_hit = rise(src_i.phy_byte_valid, phy_prev_ff); // R09
  wire [NCTX-1:0] halt_rise = ctx_halted_i & ~halted_prev_ff;
  wire fatal_hit = |halt_rise; // R12
  wire cyc_diff = (rx_cyc_i.timer_seconds_field != timer_i.timer_seconds_field) |
    (rx_cyc_i.timer_tick_field != timer_i.timer_tick_field);
  wire mismatch_hit = rise(rx_cyc_i.valid, cyc_prev_ff) & cyc_diff; // R14

  // Overrun measured from cycle start send to end of following gap
  wire [12:0] limit = 13'(OVERRUN_CYCLES);
  wire overrun_hit = (state_ff == lier_pkg::LIER_OVER) & src_i.subaction_gap_end &
    root_en_ff; // R10

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      lier_pkg::LIER_IDLE:
      begin
        if (src_i.cyc_start_tx && root_en_ff)
        begin
          nxt_state = lier_pkg::LIER_TIMING;
          nxt_cnt = 13'h0001;
        end
      end
      lier_pkg::LIER_TIMING:
      begin
        if (src_i.subaction_gap_end)
          nxt_state = lier_pkg::LIER_IDLE;
        else if (cnt_ff >= limit)
          nxt_state = lier_pkg::LIER_OVER; // R10
        else
          nxt_cnt = cnt_ff + 13'h0001;
      end
      lier_pkg::LIER_OVER:
      begin
        if (src_i.subaction_gap_end)
          nxt_state = lier_pkg::LIER_IDLE;
      end
      default:
      begin
        nxt_state = lier_pkg::LIER_IDLE;
        nxt_cnt = 13'h0000;
      end
    endcase
  end

  wire [31:0] hw_set = ({31'h0, late_hit} << `LIER_BIT_LATE) |
    ({31'h0, phy_hit} << `LIER_BIT_PHY) |
    ({31'h0, overrun_hit} << `LIER_BIT_OVERRUN) |
    ({31'h0, fatal_hit} << `LIER_BIT_FATAL) |
    ({31'h0, mismatch_hit} << `LIER_BIT_MISMATCH); // R01

  // Set wins over a clear that lands in the same cycle
  assign nxt_ev = ((ev_ff & ~sw_clr) | sw_set | hw_set) & ev_impl; // R01 R02
  wire [31:0] masked = ev_ff & mask_ff & ev_impl; // R03 R04 R07

  assign nxt_mask = wr_mask ? bus_i.wdata : mask_ff;
  assign nxt_late_en = wr_ctrl ? bus_i.wdata[`LIER_CTRL_LATE_EN] : late_en_ff;
  // Hardware clear beats a simultaneous software set of the enable
  assign nxt_root_en = overrun_hit ? 1'b0 :
    (wr_ctrl ? bus_i.wdata[`LIER_CTRL_ROOT_EN] : root_en_ff); // R11
  assign nxt_phy_byte = phy_hit ? src_i.phy_byte : phy_byte_ff; // R09
  assign nxt_block = nxt_ev[`LIER_BIT_FATAL] ? (block_ff | halt_rise) : {NCTX{1'b0}}; // R13

  wire [31:0] ctrl_val = ({31'h0, late_en_ff} << `LIER_CTRL_LATE_EN) |
    ({31'h0, root_en_ff} << `LIER_CTRL_ROOT_EN);
  wire [31:0] phy_val = {8'h00, phy_byte_ff, 16'h0000}; // R09
  wire is_ev_addr = hit(bus_i, `LIER_OFF_EV_SET) | hit(bus_i, `LIER_OFF_EV_CLR);
  wire [31:0] rd_mux = is_ev_addr ? masked : // R03
    hit(bus_i, `LIER_OFF_MASK) ? mask_ff :
    hit(bus_i, `LIER_OFF_CTRL) ? ctrl_val :
    hit(bus_i, `LIER_OFF_PHY) ? phy_val : 32'h00000000;
  assign nxt_rdata = bus_i.rd ? rd_mux : 32'h00000000;
  assign nxt_irq = |masked; // R15

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ev_ff <= `LIER_EV_RESET;
      mask_ff <= `LIER_MASK_RESET;
      late_en_ff <= 1'b0;
      root_en_ff <= 1'b0;
      phy_byte_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
      irq_ff <= 1'b0;
      block_ff <= {NCTX{1'b0}};
      halted_prev_ff <= {NCTX{1'b0}};
      late_prev_ff <= 1'b0;
      phy_prev_ff <= 1'b0;
      cyc_prev_ff <= 1'b0;
      state_ff <= lier_pkg::LIER_IDLE;
      cnt_ff <= 13'h0000;
    end
    else if (ce_i)
    begin
      ev_ff <= nxt_ev;
      mask_ff <= nxt_mask;
      late_en_ff <= nxt_late_en;
      root_en_ff <= nxt_root_en;
      phy_byte_ff <= nxt_phy_byte;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      block_ff <= nxt_block;
      halted_prev_ff <= ctx_halted_i;
      late_prev_ff <= late_lvl;
      phy_prev_ff <= src_i.phy_byte_valid;
      cyc_prev_ff <= rx_cyc_i.valid;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign rdata_o = rdata_ff;
  assign irq_o = irq_ff;
  assign ctx_block_o = block_ff;
  assign isoch_timing_root_enable_o = root_en_ff;

  // Helper for checks that look one step back across a live clock enable
  logic ce_prev_ff;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ce_prev_ff <= 1'b0;
    else
      ce_prev_ff <= ce_i;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_sw_set_bit: assert property ( // R01
    ce_i && wr_set && bus_i.wdata[`LIER_BIT_SOFT] |=> ev_ff[`LIER_BIT_SOFT])
    else $error("software set of bit 29 not latched");

  a_clear_only_write: assert property ( // R02
    ce_prev_ff && $past(!reset_i) |->
      ((($past(ev_ff) & ~ev_ff) & ~$past(sw_clr)) == 32'h00000000))
    else $error("event bit cleared without clear write");

  a_read_masked: assert property ( // R03
    ce_i && bus_i.rd && is_ev_addr |=> rdata_o == $past(ev_ff & mask_ff & ev_impl))
    else $error("event read not masked value");

  a_rsvd_zero: assert property ( // R04
    rdata_o[`LIER_BIT_RSVD31] == 1'b0 && ev_ff[`LIER_BIT_RSVD31] == 1'b0)
    else $error("bit 31 not zero");

  a_rsvd28_zero: assert property ( // R07
    rdata_o[`LIER_BIT_RSVD28] == 1'b0 && ev_ff[`LIER_BIT_RSVD28] == 1'b0)
    else $error("bit 28 not zero");

  a_soft_only_sw: assert property ( // R06
    ce_i && !(wr_set && bus_i.wdata[`LIER_BIT_SOFT]) && !ev_ff[`LIER_BIT_SOFT]
      |=> !ev_ff[`LIER_BIT_SOFT])
    else $error("software interrupt set by hardware");

  a_late_gate: assert property ( // R08
    ce_i && !late_en_ff && !(wr_set && bus_i.wdata[`LIER_BIT_LATE]) && !ev_ff[`LIER_BIT_LATE]
      |=> !ev_ff[`LIER_BIT_LATE])
    else $error("late event set while disabled");

  a_phy_byte: assert property ( // R09
    ce_i && phy_hit |=> ev_ff[`LIER_BIT_PHY] && phy_byte_ff == $past(src_i.phy_byte))
    else $error("phy byte event or data wrong");

  a_overrun_root: assert property ( // R11
    ce_i && overrun_hit |=> ev_ff[`LIER_BIT_OVERRUN] && !isoch_timing_root_enable_o)
    else $error("overrun did not clear root enable");

  a_overrun_time: assert property ( // R10
    ce_i && state_ff == lier_pkg::LIER_TIMING && !src_i.subaction_gap_end && cnt_ff < limit
      |=> state_ff != lier_pkg::LIER_OVER || cnt_ff >= limit)
    else $error("overrun flagged early");

  a_fatal_block: assert property ( // R13
    !ev_ff[`LIER_BIT_FATAL] |-> ctx_block_o == {NCTX{1'b0}})
    else $error("context blocked without fatal event");

  a_fatal_set: assert property ( // R12
    ce_i && fatal_hit |=> ev_ff[`LIER_BIT_FATAL])
    else $error("halt did not raise fatal event");

  a_mismatch: assert property ( // R14
    ce_i && mismatch_hit |=> ev_ff[`LIER_BIT_MISMATCH])
    else $error("cycle mismatch not latched");

  a_irq_level: assert property ( // R15
    ce_i |=> irq_o == $past(|(ev_ff & mask_ff & ev_impl)))
    else $error("interrupt request disagrees with masked events");

  a_ce_freeze_ev: assert property ( // R01
    !ce_i |=> ev_ff == $past(ev_ff) && mask_ff == $past(mask_ff))
    else $error("event or mask moved while clock enable low");

  a_ce_freeze_ctl: assert property ( // R11
    !ce_i |=> root_en_ff == $past(root_en_ff) && late_en_ff == $past(late_en_ff))
    else $error("control moved while clock enable low");

  a_ce_freeze_fsm: assert property ( // R10
    !ce_i |=> state_ff == $past(state_ff) && cnt_ff == $past(cnt_ff))
    else $error("overrun timer moved while clock enable low");

  a_no_stray_set: assert property ( // R01
    ce_i |=> (ev_ff & ~$past(ev_ff) & ~$past(sw_set | hw_set)) == 32'h00000000)
    else $error("event bit set without a source edge or set write");

  a_hw_set_land: assert property ( // R01
    ce_i && (|hw_set) |=> (ev_ff & $past(hw_set)) == $past(hw_set))
    else $error("hardware event edge not latched");

  a_sw_set_land: assert property ( // R01
    ce_i && wr_set |=> (ev_ff & $past(sw_set)) == $past(sw_set))
    else $error("set write not latched");

  a_sw_clr_land: assert property ( // R02
    ce_i && wr_clr |=> (ev_ff & $past(sw_clr) & ~$past(hw_set)) == 32'h00000000)
    else $error("clear write left an event bit set");

  a_impl_only: assert property ( // R04 R07
    (ev_ff & ~ev_impl) == 32'h00000000)
    else $error("unimplemented event position holds a one");

  a_rd_idle_zero: assert property ( // R03
    ce_i && !bus_i.rd |=> rdata_o == 32'h00000000)
    else $error("read data not zero outside the read reply");

  a_rd_mask_reg: assert property ( // R03
    ce_i && bus_i.rd && hit(bus_i, `LIER_OFF_MASK) |=> rdata_o == $past(mask_ff))
    else $error("mask read wrong");

  a_rd_ctrl_reg: assert property ( // R11
    ce_i && bus_i.rd && hit(bus_i, `LIER_OFF_CTRL) |=>
      rdata_o[`LIER_CTRL_ROOT_EN] == $past(root_en_ff) &&
      rdata_o[`LIER_CTRL_LATE_EN] == $past(late_en_ff))
    else $error("control read wrong");

  a_rd_phy_byte: assert property ( // R09
    ce_i && bus_i.rd && hit(bus_i, `LIER_OFF_PHY) |=>
      rdata_o == {8'h00, $past(phy_byte_ff), 16'h0000})
    else $error("phy byte read wrong");

  a_phy_hold: assert property ( // R09
    ce_i && !phy_hit |=> phy_byte_ff == $past(phy_byte_ff))
    else $error("phy byte changed without a new byte");

  a_mask_write: assert property ( // R03
    ce_i && wr_mask |=> mask_ff == $past(bus_i.wdata))
    else $error("mask write not stored");

  a_ctrl_write: assert property ( // R08
    ce_i && wr_ctrl |=> late_en_ff == $past(bus_i.wdata[`LIER_CTRL_LATE_EN]))
    else $error("late acknowledge enable write not stored");

  a_late_set: assert property ( // R08
    ce_i && late_hit |=> ev_ff[`LIER_BIT_LATE])
    else $error("late acknowledge edge not latched");

  a_root_start: assert property ( // R10
    ce_i && state_ff == lier_pkg::LIER_IDLE && src_i.cyc_start_tx && root_en_ff
      |=> state_ff == lier_pkg::LIER_TIMING && cnt_ff == 13'h0001)
    else $error("cycle start did not start the overrun timer");

  a_over_enter: assert property ( // R10
    ce_i && state_ff == lier_pkg::LIER_TIMING && !src_i.subaction_gap_end && cnt_ff >= limit
      |=> state_ff == lier_pkg::LIER_OVER)
    else $error("overrun limit passed without overrun state");

  a_gap_ends_run: assert property ( // R10
    ce_i && state_ff != lier_pkg::LIER_IDLE && src_i.subaction_gap_end
      |=> state_ff == lier_pkg::LIER_IDLE)
    else $error("gap end did not stop the overrun timer");

  a_cnt_bound: assert property ( // R10
    cnt_ff <= limit)
    else $error("overrun counter passed its limit");

  a_root_clr_only: assert property ( // R11
    ce_i && !overrun_hit && !wr_ctrl |=> root_en_ff == $past(root_en_ff))
    else $error("root enable changed without overrun or write");

  a_fatal_ctx: assert property ( // R13
    ce_i && fatal_hit |=> (ctx_block_o & $past(halt_rise)) == $past(halt_rise))
    else $error("halted context not blocked");

  a_fatal_hold: assert property ( // R13
    ce_i && ev_ff[`LIER_BIT_FATAL] && !sw_clr[`LIER_BIT_FATAL]
      |=> (ctx_block_o & $past(ctx_block_o)) == $past(ctx_block_o))
    else $error("blocked context released while fatal event stands");

  a_block_release: assert property ( // R13
    ce_i && sw_clr[`LIER_BIT_FATAL] && !fatal_hit |=> ctx_block_o == {NCTX{1'b0}})
    else $error("blocked contexts kept after fatal event cleared");

  a_irq_quiet: assert property ( // R15
    ce_i && (ev_ff & mask_ff) == 32'h00000000 |=> !irq_o)
    else $error("interrupt request without a masked event");

endmodule : lier_top
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} lier_row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce = 1'b1;
  lier_pkg::lier_bus_t bus = '0;
  lier_pkg::lier_src_t src = '0;
  lier_pkg::lier_cyc_t rxc = '0;
  lier_pkg::lier_cyc_t tmr = '0;
  logic [3:0] halt = 4'h0;
  logic [31:0] rdata;
  logic [3:0] blk;
  logic root;
  logic irq;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Event bit 30 is never written at the set or clear address: software must leave it alone
  lier_row_t rows [14] = '{
    '{1'b1, 8'h88, 32'hffffffff}, '{1'b0, 8'h80, 32'h00000000},
    '{1'b1, 8'h80, 32'h20000000}, '{1'b0, 8'h84, 32'h20000000},
    '{1'b1, 8'h84, 32'h20000000}, '{1'b0, 8'h80, 32'h00000000},
    '{1'b1, 8'h80, 32'hbfffffff}, '{1'b0, 8'h80, 32'h2f800000},
    '{1'b1, 8'h88, 32'h08800000}, '{1'b0, 8'h84, 32'h08800000},
    '{1'b1, 8'h84, 32'hbfffffff}, '{1'b1, 8'h88, 32'hffffffff},
    '{1'b0, 8'h80, 32'h00000000}, '{1'b0, 8'h44, 32'h00000000}};

  lier_top #(.NCTX(4), .OVERRUN_CYCLES(20)) lier_top_i (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce), .bus_i(bus), .rdata_o(rdata), .src_i(src), .rx_cyc_i(rxc), .timer_i(tmr),
    .ctx_halted_i(halt), .ctx_block_o(blk), .isoch_timing_root_enable_o(root), .irq_o(irq));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      $display("ERROR at %0t: run too long", $time);
      test_done();
    end
  end

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask : ticks

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 chk32(rdata, exp);
    @(posedge clk_i);
  endtask : rd

  // Cycle start, n idle cycles, gap end; overrun only counts while the root is enabled
  task span(input int n, input logic [31:0] exp);
    ticks(1);
    src.cyc_start_tx <= 1'b1;
    ticks(1);
    src.cyc_start_tx <= 1'b0;
    ticks(n);
    src.subaction_gap_end <= 1'b1;
    ticks(1);
    src.subaction_gap_end <= 1'b0;
    ticks(3);
    rd(8'h80, exp);
  endtask : span

  initial
  begin
    ticks(16);
    reset_i <= 1'b0;
    #1 chk1(irq, 1'b0);
    for (int i = 0; i < 14; i++)
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      else
        rd(rows[i].a, rows[i].d);
    $display("register table test done");
    wr(8'h80, 32'h20000000);
    ticks(2);
    #1 chk1(irq, 1'b1);
    wr(8'h88, 32'h00000000);
    ticks(2);
    #1 chk1(irq, 1'b0);
    wr(8'h88, 32'hffffffff);
    wr(8'h84, 32'h20000000);
    $display("request line test done");
    src.phy_byte <= 8'ha5;
    src.phy_byte_valid <= 1'b1;
    ticks(3);
    rd(8'h80, 32'h04000000);
    rd(8'h90, 32'h00a50000);
    wr(8'h84, 32'h04000000);
    ticks(3);
    rd(8'h80, 32'h00000000);
    src.phy_byte_valid <= 1'b0;
    $display("phy byte test done");
    src.rx_fifo_pending <= 1'b1;
    ticks(3);
    rd(8'h80, 32'h00000000);
    src.rx_fifo_pending <= 1'b0;
    wr(8'h8c, 32'h20000000);
    for (int k = 0; k < 3; k++)
    begin
      src[13 - k] <= 1'b1;
      ticks(3);
      rd(8'h80, 32'h08000000);
      src[13 - k] <= 1'b0;
      ticks(2);
      wr(8'h84, 32'h08000000);
    end
    $display("late acknowledge test done");
    halt <= 4'h2;
    ticks(3);
    rd(8'h80, 32'h01000000);
    #1 chk32({28'h0000000, blk}, 32'h00000002);
    wr(8'h84, 32'h01000000);
    halt <= 4'h0;
    ticks(2);
    #1 chk32({28'h0000000, blk}, 32'h00000000);
    ticks(1);
    tmr <= '{1'b0, 7'h05, 13'h0123};
    for (int k = 0; k < 3; k++)
    begin
      rxc <= '{1'b1, 7'(5 + (k == 2)), 13'(291 + (k == 1))};
      ticks(3);
      rd(8'h80, (k > 0) ? 32'h00800000 : 32'h00000000);
      rxc.valid <= 1'b0;
      wr(8'h84, 32'h00800000);
    end
    $display("fault and timer test done");
    wr(8'h8c, 32'h00200000);
    ticks(2);
    #1 chk1(root, 1'b1);
    span(5, 32'h00000000);
    span(19, 32'h00000000);
    span(20, 32'h02000000);
    #1 chk1(root, 1'b0);
    rd(8'h8c, 32'h00000000);
    wr(8'h84, 32'h02000000);
    span(25, 32'h00000000);
    ce <= 1'b0;
    wr(8'h80, 32'h20000000);
    ce <= 1'b1;
    rd(8'h80, 32'h00000000);
    $display("overrun test done");
    wr(8'h80, 32'h20000000);
    reset_i <= 1'b1;
    ticks(2);
    reset_i <= 1'b0;
    rd(8'h80, 32'h00000000);
    rd(8'h88, 32'h00000000);
    $display("reset test done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
